// ### verif/swp_pwm_chk.sv
// Port-level checker for the four-channel pulse generator
`timescale 1ns/1ps
module swp_pwm_chk import swp_pkg::*; (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  chanEnable,
  input wire logic [3:0]  defaultLoadInput,
  input wire logic [3:0]  done,
  input wire logic        programErrorFlag,
  input wire logic        channelOnePin,
  input wire logic        channelTwoPin,
  input wire logic        channelThreePin,
  input wire logic        channelFourPin
);
  logic [3:0] prevEn;
  logic [2:0] riseWin;
  logic       apbAcc;
  logic       clrWr;
  assign apbAcc = psel && penable;
  assign clrWr  = apbAcc && pwrite && paddr[11:2] == IDX_STATUS && pwdata[STAT_PROG_ERR];
  // Recent enable rises
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevEn  <= 4'h0;
      riseWin <= 3'h0;
    end else begin
      prevEn  <= chanEnable;
      riseWin <= {riseWin[1:0], |(chanEnable & ~prevEn)};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_all_off;
    (chanEnable == 4'h0) [*2];
  endsequence
  a_ready_access: assert property (apbAcc |-> pready)
    else $error("pready low in access cycle");
  a_ready_idle: assert property (!apbAcc |-> !pready && !pslverr)
    else $error("pready or pslverr outside access");
  a_block_mapped: assert property (apbAcc && paddr[11:2] < IDX_BLOCK_END
    && paddr[4:2] != 3'h7 |-> !pslverr)
    else $error("control word refused");
  a_beyond_map: assert property (apbAcc && paddr[11:2] > IDX_STATUS |-> pslverr)
    else $error("unmapped access accepted");
  a_unmapped_zero: assert property (apbAcc && !pwrite && pslverr |->
    prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_done_gated: assert property ((done & ~chanEnable) == 4'h0)
    else $error("done high with enable low");
  a_pins_idle: assert property (s_all_off |->
    {channelFourPin, channelThreePin, channelTwoPin, channelOnePin} == 4'h0)
    else $error("pin active while disabled");
  a_err_sticky: assert property (programErrorFlag && !clrWr |=> programErrorFlag)
    else $error("program error flag dropped");
  a_err_cause: assert property ($rose(programErrorFlag) |-> riseWin != 3'h0)
    else $error("program error without enable rise");
endmodule
bind swp_pwm_top swp_pwm_chk u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .chanEnable, .defaultLoadInput, .done, .programErrorFlag,
  .channelOnePin, .channelTwoPin, .channelThreePin, .channelFourPin);

// ### verif/swp_pwm_top_tb.sv
// Self-checking bench for the four-channel pulse generator
`timescale 1ns/1ps
module swp_pwm_top_tb;
  import swp_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, programErrorFlag, clrMeas;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, chanEnable, defaultLoadInput, done, enReq, loadReq, pins;
  logic [31:0] highCnt [4];
  logic        rerr;
  int          n_errors, total_checks;
  logic [31:0] rstWord [7] = '{32'h64, 32'h32, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
  logic [31:0] freqT [5] = '{32'h0, 32'h3E9, 32'h64, 32'h64, 32'h64};
  logic [31:0] dutyT [5] = '{32'h32, 32'h32, 32'h0, 32'h65, 32'h32};
  logic [31:0] preT [5]  = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h0};
  logic [31:0] modeT [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
  logic [31:0] codeT [5] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h4};
  logic [31:0] dutyW [4] = '{32'h29, 32'h14, 32'h15, 32'h64};
  logic [31:0] hiExp [4] = '{32'h1770, 32'h7D0, 32'hFA0, 32'h2710};
  logic        channelOnePin, channelTwoPin, channelThreePin, channelFourPin;

  assign pins = {channelFourPin, channelThreePin, channelTwoPin, channelOnePin};

  swp_scan_partner u_scan (.clk(clk), .rstn(rstn), .enReq(enReq), .loadReq(loadReq),
    .pins(pins), .clrMeas(clrMeas), .chanEnable(chanEnable),
    .defaultLoadInput(defaultLoadInput), .highCnt(highCnt));

  swp_pwm_top #(.SCAN_PERIOD(50), .TICK_PERIOD(10)) u_dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chanEnable(chanEnable),
    .defaultLoadInput(defaultLoadInput), .done(done), .programErrorFlag(programErrorFlag),
    .channelOnePin(channelOnePin), .channelTwoPin(channelTwoPin),
    .channelThreePin(channelThreePin), .channelFourPin(channelFourPin));

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp(rdat, exp);
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(8 * 40000);
    n_errors++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pstrb = 4'hF; enReq = 4'h0; loadReq = 4'h0; clrMeas = 1'b0;
    n_errors = 0; total_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int w = 0; w < 7; w++) rd(10'(w), rstWord[w]);
    rd(IDX_STATUS, 32'h0);
    apb(1'b0, 10'h3FF, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    apb(1'b1, 10'(W_COUNT_LO), 32'hBEEF);
    rd(10'(W_COUNT_LO), 32'h0);
    apb(1'b1, IDX_CTRL, 32'h10F);
    rd(IDX_CTRL, 32'h103);
    rd(10'(W_PRESET_HI), 32'h1);
    rd(10'(W_PRESET_LO), 32'h0);
    apb(1'b1, IDX_CTRL, 32'h0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 10'h0, freqT[k]);
      apb(1'b1, 10'h1, dutyT[k]);
      apb(1'b1, 10'h3, preT[k]);
      apb(1'b1, IDX_CTRL, modeT[k]);
      enReq <= 4'h1;
      repeat (6) @(posedge clk);
      cmp({31'h0, programErrorFlag}, 32'h1);
      rd(10'h6, codeT[k]);
      apb(1'b0, IDX_STATUS, 32'h0);
      cmp(rdat & 32'h8001, 32'h8000);
      enReq <= 4'h0;
      repeat (3) @(posedge clk);
      apb(1'b1, IDX_STATUS, 32'h8000);
      cmp({31'h0, programErrorFlag}, 32'h0);
    end
    apb(1'b1, IDX_CTRL, 32'h0);
    // default load, then ignored while enabled
    apb(1'b1, 10'h8, 32'h1F4);
    loadReq <= 4'h2;
    repeat (120) @(posedge clk);
    rd(10'h8, 32'h64);
    rd(10'h9, 32'h32);
    enReq <= 4'h2;
    repeat (4) @(posedge clk);
    apb(1'b1, 10'h8, 32'h1F4);
    repeat (120) @(posedge clk);
    rd(10'h8, 32'h1F4);
    enReq <= 4'h0;
    loadReq <= 4'h0;
    repeat (4) @(posedge clk);
    // duty rounding per pin at 1000 Hz
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 10'(8 * c), 32'h3E8);
      apb(1'b1, 10'(8 * c + 1), dutyW[c]);
    end
    enReq <= 4'hF;
    clrMeas <= 1'b1;
    @(posedge clk);
    clrMeas <= 1'b0;
    repeat (4) @(posedge clk);
    rd(IDX_STATUS, 32'h249);
    cmp({28'h0, done}, 32'h0);
    repeat (9993) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      total_checks++;
      if ((highCnt[c] + 50 >= hiExp[c] && highCnt[c] <= hiExp[c] + 50) !== 1'b1) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, highCnt[c], hiExp[c]);
      end
    end
    enReq <= 4'h0;
    repeat (4) @(posedge clk);
    rd(IDX_STATUS, 32'h492);
    cmp({28'h0, done}, 32'h0);
    apb(1'b1, IDX_CTRL, 32'h1);
    apb(1'b1, 10'(W_PRESET_LO), 32'h3);
    enReq <= 4'h1;
    repeat (1500) @(posedge clk);
    rd(10'(W_COUNT_LO), 32'h1);
    rd(IDX_STATUS, 32'h491);
    repeat (2000) @(posedge clk);
    rd(10'(W_COUNT_LO), 32'h3);
    rd(10'(W_COUNT_HI), 32'h0);
    rd(IDX_STATUS, 32'h492);
    cmp({28'h0, done}, 32'h1);
    cmp({31'h0, channelOnePin}, 32'h0);
    enReq <= 4'h0;
    repeat (4) @(posedge clk);
    apb(1'b1, 10'(W_PRESET_LO), 32'h64);
    enReq <= 4'h1;
    repeat (60) @(posedge clk);
    rd(10'(W_COUNT_LO), 32'h0);
    rd(IDX_STATUS, 32'h491);
    repeat (2500) @(posedge clk);
    apb(1'b1, 10'(W_PRESET_LO), 32'h1);
    repeat (4) @(posedge clk);
    rd(IDX_STATUS, 32'h496);
    enReq <= 4'h0;
    give_verdict();
  end
endmodule

// ### verif/swp_scan_partner.sv
// Program scan and actuator model: drives enables, measures pin high time
`timescale 1ns/1ps
module swp_scan_partner (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  enReq,
  input  wire logic [3:0]  loadReq,
  input  wire logic [3:0]  pins,
  input  wire logic        clrMeas,
  output logic      [3:0]  chanEnable,
  output logic      [3:0]  defaultLoadInput,
  output logic      [31:0] highCnt [4]
);
  // Scan-side inputs, one register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chanEnable       <= 4'h0;
      defaultLoadInput <= 4'h0;
    end else begin
      chanEnable       <= enReq;
      defaultLoadInput <= loadReq;
    end
  end
  // Actuator high-time counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        highCnt[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (clrMeas) begin
          highCnt[i] <= 32'h00000000;
        end else if (pins[i]) begin
          highCnt[i] <= highCnt[i] + 32'h00000001;
        end
      end
    end
  end
endmodule

// ### verilog/swp_channel.sv
// One pulse engine: phase accumulator, counting, status flags
`timescale 1ns/1ps
module swp_channel import swp_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        tick,
  input  wire logic        scanPulse,
  input  wire logic        startReq,
  input  wire logic        enable,
  input  wire logic        countMode,
  input  wire logic [15:0] freq,
  input  wire logic [6:0]  effDuty,
  input  wire logic [31:0] preset,
  output logic             pin,
  output logic             running,
  output logic             complete,
  output logic             overflow,
  output logic [31:0]      pulseCount
);

  swp_state_t  state;
  logic [16:0] phase;
  logic [31:0] liveCount;
  logic [17:0] next_phase;
  logic        wrap;
  logic        lastPulse;
  logic        beyond;

  assign next_phase = {1'b0, phase} + {2'b00, freq};
  assign wrap       = next_phase >= {1'b0, PHASE_WRAP};
  assign lastPulse  = countMode && (liveCount + 32'h1 >= preset);
  assign beyond     = countMode && (liveCount > preset);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= SWP_IDLE;
      phase     <= 17'h00000;
      liveCount <= 32'h00000000;
      running   <= 1'b0;
      complete  <= 1'b0;
      overflow  <= 1'b0;
    end else if (startReq) begin
      state     <= SWP_RUN;
      phase     <= 17'h00000;
      liveCount <= 32'h00000000;
      running   <= 1'b1;
      complete  <= 1'b0;
      overflow  <= 1'b0;
    end else begin
      case (state)
        SWP_RUN: begin
          if (!enable) begin
            state    <= SWP_IDLE;
            running  <= 1'b0;
            complete <= 1'b1;
          end else if (beyond) begin
            overflow <= 1'b1;
            state    <= SWP_IDLE;
            running  <= 1'b0;
            complete <= 1'b1;
          end else if (tick) begin
            if (wrap) begin
              phase     <= 17'(next_phase - {1'b0, PHASE_WRAP});
              liveCount <= liveCount + 32'h1;
              if (lastPulse) begin
                state    <= SWP_IDLE;
                running  <= 1'b0;
                complete <= 1'b1;
              end
            end else begin
              phase <= next_phase[16:0];
            end
          end
        end
        SWP_IDLE: begin
          phase <= 17'h00000;
        end
        default: begin
          state <= SWP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin <= 1'b0;
    end else begin
      pin <= (state == SWP_RUN) && enable && (phase < 17'(effDuty) * PHASE_PER_PCT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseCount <= 32'h00000000;
    end else if (startReq) begin
      pulseCount <= 32'h00000000;
    end else if (scanPulse) begin
      pulseCount <= liveCount;
    end
  end

endmodule

// ### verilog/swp_pkg.sv
// Package of constants, map and helpers for the scan-driven pulse generator
package swp_pkg;

  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned TICK_HZ      = 100000;
  localparam int unsigned TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int unsigned SCAN_US      = 1000;
  localparam int unsigned SCAN_CYCLES  = SCAN_US * (CLK_HZ / 1000000);
  localparam logic [16:0] PHASE_WRAP   = 17'(TICK_HZ);
  localparam logic [16:0] PHASE_PER_PCT = 17'(TICK_HZ / 100);

  localparam int unsigned NUM_CHAN     = 4;
  localparam int unsigned NUM_COUNTING = 2;
  localparam int unsigned BLOCK_WORDS  = 7;
  localparam int unsigned BLOCK_STRIDE = 8;

  // Word indexes inside a control block
  localparam logic [2:0] W_FREQ        = 3'h0;
  localparam logic [2:0] W_DUTY        = 3'h1;
  localparam logic [2:0] W_PRESET_HI   = 3'h2;
  localparam logic [2:0] W_PRESET_LO   = 3'h3;
  localparam logic [2:0] W_COUNT_HI    = 3'h4;
  localparam logic [2:0] W_COUNT_LO    = 3'h5;
  localparam logic [2:0] W_ERROR       = 3'h6;

  // Global register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CTRL      = 10'h020;
  localparam logic [9:0] IDX_STATUS    = 10'h021;
  localparam logic [9:0] IDX_BLOCK_END = 10'h020;

  // Field positions
  localparam int unsigned CTRL_WORD_ORDER = 8;
  localparam int unsigned STAT_PROG_ERR   = 15;
  localparam int unsigned FLAG_RUNNING    = 0;
  localparam int unsigned FLAG_COMPLETE   = 1;
  localparam int unsigned FLAG_OVERFLOW   = 2;
  localparam int unsigned FLAGS_PER_CHAN  = 3;

  // Ranges and defaults
  localparam logic [15:0] FREQ_MIN     = 16'h0001;
  localparam logic [15:0] FREQ_MAX     = 16'h03E8;
  localparam logic [15:0] DUTY_MIN     = 16'h0001;
  localparam logic [15:0] DUTY_MAX     = 16'h0064;
  localparam logic [31:0] PRESET_MIN   = 32'h00000001;
  localparam logic [31:0] PRESET_MAX   = 32'h05F5E100;
  localparam logic [15:0] FREQ_FINE    = 16'h0032;
  localparam logic [15:0] DEF_FREQ     = 16'h0064;
  localparam logic [15:0] DEF_DUTY     = 16'h0032;

  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_FREQ     = 16'h0001;
  localparam logic [15:0] ERR_DUTY     = 16'h0002;
  localparam logic [15:0] ERR_PRESET   = 16'h0004;

  typedef enum logic {SWP_IDLE, SWP_RUN} swp_state_t;

  // Duty after step rounding, capped at 100
  function automatic logic [6:0] swp_eff_duty(input logic [15:0] freq, input logic [15:0] duty);
    logic [6:0]  step;
    logic [15:0] mult;
    logic [6:0]  result;
    step   = 7'h01;
    result = 7'h64;
    for (int k = 1; k < 20; k++) begin
      if (freq > 16'(50 * k)) begin
        step = 7'(k + 1);
      end
    end
    for (int k = 100; k >= 1; k--) begin
      mult = 16'(k) * 16'(step);
      if (mult >= duty && mult <= DUTY_MAX) begin
        result = mult[6:0];
      end
    end
    return result;
  endfunction

  // Settings check made at enable rise
  function automatic logic [15:0] swp_check(input logic [15:0] freq, input logic [15:0] duty,
                                            input logic [31:0] preset, input logic counting);
    if (freq < FREQ_MIN || freq > FREQ_MAX) begin
      return ERR_FREQ;
    end
    if (duty < DUTY_MIN || duty > DUTY_MAX) begin
      return ERR_DUTY;
    end
    if (counting && (preset < PRESET_MIN || preset > PRESET_MAX)) begin
      return ERR_PRESET;
    end
    return ERR_NONE;
  endfunction

endpackage

// ### verilog/swp_pwm_top.sv
// Four-channel scan-driven pulse generator with APB register access
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module swp_pwm_top import swp_pkg::*; #(
  parameter int unsigned SCAN_PERIOD = SCAN_CYCLES,
  parameter int unsigned TICK_PERIOD = TICK_DIV,
  parameter logic [31:0] DEF_PRESET  = 32'h00000001
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  chanEnable,
  input  wire logic [3:0]  defaultLoadInput,
  output logic [3:0]       done,
  output logic             programErrorFlag,
  output logic             channelOnePin,
  output logic             channelTwoPin,
  output logic             channelThreePin,
  output logic             channelFourPin
);

  logic [15:0] freqReg   [0:NUM_CHAN-1];
  logic [15:0] dutyReg   [0:NUM_CHAN-1];
  logic [31:0] presetReg [0:NUM_CHAN-1];
  logic [15:0] errCode   [0:NUM_CHAN-1];
  logic [31:0] pulseCnt  [0:NUM_CHAN-1];
  logic [6:0]  effDuty   [0:NUM_CHAN-1];
  logic [NUM_COUNTING-1:0] countModeReg;
  logic        wordOrder;
  logic [3:0]  enPrev;
  logic [3:0]  enRise;
  logic [3:0]  startReq;
  logic [3:0]  setupOk;
  logic [3:0]  running;
  logic [3:0]  complete;
  logic [3:0]  overflow;
  logic [3:0]  pins;
  logic [3:0]  chanCount;
  logic [15:0] flagWord;
  logic [31:0] scanCnt;
  logic        scanPulse;
  logic [15:0] tickCnt;
  logic        tick;
  logic [9:0]  idx;
  logic [1:0]  selChan;
  logic [2:0]  selWord;
  logic        inBlock;
  logic        mapped;
  logic        wrAccess;
  logic        setup;
  logic [31:0] next_prdata;

  // Half of a 32-bit word held at an upper-half offset
  function automatic logic isUpper(input logic [2:0] word, input logic order);
    return ((word == W_PRESET_HI) || (word == W_COUNT_HI)) ^ order;
  endfunction

  assign idx      = paddr[11:2];
  assign selChan  = idx[4:3];
  assign selWord  = idx[2:0];
  assign inBlock  = (idx < IDX_BLOCK_END) && (selWord < 3'(BLOCK_WORDS));
  assign mapped   = inBlock || (idx == IDX_CTRL) || (idx == IDX_STATUS);
  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite && mapped;
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped;

  // Frequency time base
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (tickCnt == 16'(TICK_PERIOD - 1)) begin
      tickCnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // Program scan divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scanCnt   <= 32'h00000000;
      scanPulse <= 1'b0;
    end else if (scanCnt == 32'(SCAN_PERIOD - 1)) begin
      scanCnt   <= 32'h00000000;
      scanPulse <= 1'b1;
    end else begin
      scanCnt   <= scanCnt + 32'h00000001;
      scanPulse <= 1'b0;
    end
  end

  // Enable edge tracking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enPrev <= 4'h0;
    end else begin
      enPrev <= chanEnable;
    end
  end

  assign enRise = chanEnable & ~enPrev;

  // counting only on first two channels
  assign chanCount = {2'b00, countModeReg};

  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      setupOk[c]  = swp_check(freqReg[c], dutyReg[c], presetReg[c], chanCount[c]) == ERR_NONE;
      startReq[c] = enRise[c] && setupOk[c];
    end
  end

  // Control words, error codes and defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        freqReg[c]   <= DEF_FREQ;
        dutyReg[c]   <= DEF_DUTY;
        presetReg[c] <= 32'h00000001;
        errCode[c]   <= ERR_NONE;
      end
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (wrAccess && inBlock && selChan == 2'(c)) begin
          case (selWord)
            W_FREQ: freqReg[c] <= pwdata[15:0];
            W_DUTY: dutyReg[c] <= pwdata[15:0];
            W_PRESET_HI, W_PRESET_LO: begin
              if (isUpper(selWord, wordOrder)) begin
                presetReg[c][31:16] <= pwdata[15:0];
              end else begin
                presetReg[c][15:0] <= pwdata[15:0];
              end
            end
            default: begin
            end
          endcase
        end
        if (defaultLoadInput[c] && !chanEnable[c] && scanPulse) begin
          freqReg[c]   <= DEF_FREQ;
          dutyReg[c]   <= DEF_DUTY;
          presetReg[c] <= DEF_PRESET;
        end
        if (enRise[c]) begin
          errCode[c] <= swp_check(freqReg[c], dutyReg[c], presetReg[c], chanCount[c]);
        end
      end
    end
  end

  // Global control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countModeReg <= '0;
      wordOrder    <= 1'b0;
    end else if (wrAccess && idx == IDX_CTRL) begin
      // counting option on channels one and two
      countModeReg <= pwdata[NUM_COUNTING-1:0];
      wordOrder    <= pwdata[CTRL_WORD_ORDER];
    end
  end

  // sticky error flag, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      programErrorFlag <= 1'b0;
    end else if (|(enRise & ~setupOk)) begin
      programErrorFlag <= 1'b1;
    end else if (wrAccess && idx == IDX_STATUS && pwdata[STAT_PROG_ERR]) begin
      programErrorFlag <= 1'b0;
    end
  end

  for (genvar g = 0; g < NUM_CHAN; g++) begin : gChan
    assign effDuty[g] = swp_eff_duty(freqReg[g], dutyReg[g]);
    swp_channel uChan (
      .clk        (clk),
      .rstn       (rstn),
      .tick       (tick),
      .scanPulse  (scanPulse),
      .startReq   (startReq[g]),
      .enable     (chanEnable[g]),
      .countMode  (chanCount[g]),
      .freq       (freqReg[g]),
      .effDuty    (effDuty[g]),
      .preset     (presetReg[g]),
      .pin        (pins[g]),
      .running    (running[g]),
      .complete   (complete[g]),
      .overflow   (overflow[g]),
      .pulseCount (pulseCnt[g])
    );
  end

  assign channelOnePin   = pins[0];
  assign channelTwoPin   = pins[1];
  assign channelThreePin = pins[2];
  assign channelFourPin  = pins[3];

  assign done = complete & chanEnable;

  always_comb begin
    flagWord = 16'h0000;
    for (int c = 0; c < NUM_CHAN; c++) begin
      flagWord[FLAGS_PER_CHAN*c+FLAG_RUNNING]  = running[c];
      flagWord[FLAGS_PER_CHAN*c+FLAG_COMPLETE] = complete[c];
      flagWord[FLAGS_PER_CHAN*c+FLAG_OVERFLOW] = overflow[c];
    end
    flagWord[STAT_PROG_ERR] = programErrorFlag;
  end

  // Read data selection
  always_comb begin
    next_prdata = 32'h00000000;
    if (inBlock) begin
      case (selWord)
        W_FREQ:      next_prdata = {16'h0000, freqReg[selChan]};
        W_DUTY:      next_prdata = {16'h0000, dutyReg[selChan]};
        W_PRESET_HI, W_PRESET_LO: begin
          next_prdata = isUpper(selWord, wordOrder) ? {16'h0000, presetReg[selChan][31:16]}
                                                    : {16'h0000, presetReg[selChan][15:0]};
        end
        W_COUNT_HI, W_COUNT_LO: begin
          next_prdata = isUpper(selWord, wordOrder) ? {16'h0000, pulseCnt[selChan][31:16]}
                                                    : {16'h0000, pulseCnt[selChan][15:0]};
        end
        W_ERROR:     next_prdata = {16'h0000, errCode[selChan]};
        default:     next_prdata = 32'h00000000;
      endcase
    end else if (idx == IDX_CTRL) begin
      next_prdata[NUM_COUNTING-1:0] = countModeReg;
      next_prdata[CTRL_WORD_ORDER]  = wordOrder;
    end else if (idx == IDX_STATUS) begin
      next_prdata = {16'h0000, flagWord};
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end

endmodule
